// File: cmp_gate_map.svh
`ifndef CMP_GATE_MAP_SVH
`define CMP_GATE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SYNC_GATE_CFG_ADDR   4'h0
`define LADDER_CTRL_ADDR     4'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_SYNC_BIT         0
`define CFG_GSRC_BIT         1
`define LAD_EN_BIT           7
`define LAD_RANGE_BIT        5
`define LAD_LEVEL_MSB        3
`define LAD_LEVEL_LSB        0

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define SYNC_GATE_CFG_RST    8'h02
`define LADDER_CTRL_RST      8'h00
`define CFG_WRITE_MASK       8'h03
`define LAD_WRITE_MASK       8'haf

// ----------------------------------------------------------------
// reference ratio, expressed in 1/96 of supply
// ----------------------------------------------------------------
`define REF_DENOM            7'h60
`define REF_LOW_STEP         7'h04
`define REF_HIGH_BASE        7'h18
`define REF_HIGH_STEP        7'h03

`endif

// File: cmp_gate_pkg.sv
package cmp_gate_pkg;

    // ------------------------------------------------------------
    // shared types
    // ------------------------------------------------------------
    typedef logic [7:0] reg8_t;
    typedef logic [6:0] ratio_t;

    // timer prescale choice, taken from the timer control logic
    typedef enum logic [1:0]
    {
        PRESC_1 = 2'h0,
        PRESC_2 = 2'h1,
        PRESC_4 = 2'h2,
        PRESC_8 = 2'h3
    } presc_t;

endpackage

// File: cmp_catch_latch.sv
`timescale 1ns/1ps
`include "cmp_gate_map.svh"

module cmp_catch_latch
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic capture,
    input  wire logic d,
    output logic      q
);

    // ------------------------------------------------------------
    // catch on the strobe, hold otherwise
    // ------------------------------------------------------------
    // no strobe means no change, so a stopped timer clock freezes q
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            q <= 1'b0;
        else if (capture)
            q <= d;
    end

    property p_hold;
        @(posedge clk) disable iff (!arst_n)
        !capture |=> $stable(q);
    endproperty
    a_hold: assert property (p_hold) else $error("latch changed without capture");

    property p_catch;
        @(posedge clk) disable iff (!arst_n)
        capture |=> q == $past(d);
    endproperty
    a_catch: assert property (p_catch) else $error("latch missed captured value");

endmodule // cmp_catch_latch

// File: cmp_sync_ref_ctrl.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "cmp_gate_map.svh"

module cmp_sync_ref_ctrl
    import cmp_gate_pkg::*;
#(
    parameter int ADDR_W  = 4,
    parameter int TIMER_W = 16
)
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic [ADDR_W-1:0]  addr,
    input  wire logic [7:0]         wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic [7:0]              rd_data,
    input  wire logic               comparator_in,
    input  wire logic               timer_clk_src,
    input  wire logic [1:0]         timer_prescale,
    input  wire logic               timer_on,
    input  wire logic               timer_gate_enable,
    input  wire logic               timer_gate_pin_n,
    output logic                    comparator_result,
    output logic                    timer_gate_active,
    output logic [TIMER_W-1:0]      timer_count,
    output logic                    ladder_power_on,
    output logic                    reference_range_select,
    output logic [3:0]              reference_level,
    output logic [6:0]              comparator_reference_output
);

    // ------------------------------------------------------------
    // registers and internal state
    // ------------------------------------------------------------
    reg8_t                cfg_q;
    reg8_t                lad_q;
    reg8_t                rd_data_q;
    logic                 src_prev_q;
    logic [2:0]           presc_cnt_q;
    logic                 presc_prev_q;
    logic [TIMER_W-1:0]   timer_q;
    logic                 presc_level;
    logic                 src_rise;
    logic                 tick_rise;
    logic                 tick_fall;
    logic                 latched_result;
    logic                 comparator_sync_enable;
    logic                 timer_gate_source_select;
    logic                 reference_enable;
    logic                 count_en;
    logic                 cfg_hit;
    logic                 lad_hit;
    presc_t               presc_sel;
    ratio_t               ratio;

    assign presc_sel                = presc_t'(timer_prescale);
    assign cfg_hit                  = addr == ADDR_W'(`SYNC_GATE_CFG_ADDR);
    assign lad_hit                  = addr == ADDR_W'(`LADDER_CTRL_ADDR);
    assign comparator_sync_enable   = cfg_q[`CFG_SYNC_BIT];
    assign timer_gate_source_select = cfg_q[`CFG_GSRC_BIT];
    assign reference_enable         = lad_q[`LAD_EN_BIT];

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // unimplemented bits are masked on write so they stay zero for good
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cfg_q <= `SYNC_GATE_CFG_RST;
        else if (wr_en && cfg_hit)
            cfg_q <= wr_data & `CFG_WRITE_MASK;
    end

    // ladder control has its own write path, untouched by the config
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lad_q <= `LADDER_CTRL_RST;
        else if (wr_en && lad_hit)
            lad_q <= wr_data & `LAD_WRITE_MASK;
    end

    // ------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ------------------------------------------------------------
    // unmapped addresses and idle cycles read as zero
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_data_q <= 8'h00;
        else if (rd_en && cfg_hit)
            rd_data_q <= cfg_q;
        else if (rd_en && lad_hit)
            rd_data_q <= lad_q;
        else
            rd_data_q <= 8'h00;
    end

    assign rd_data = rd_data_q;

    // ------------------------------------------------------------
    // timer clock edges and prescaler
    // ------------------------------------------------------------
    // the raw source is sampled each clk, so its edges become strobes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            src_prev_q <= 1'b0;
        else
            src_prev_q <= timer_clk_src;
    end

    assign src_rise = timer_clk_src && !src_prev_q;

    // divider advances on source rising edges only
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            presc_cnt_q <= 3'h0;
        else if (src_rise)
            presc_cnt_q <= presc_cnt_q + 3'h1;
    end

    // prescaled clock level; ratio 1 is the raw source itself
    always_comb
    begin
        unique case (presc_sel)
            PRESC_1: presc_level = timer_clk_src;
            PRESC_2: presc_level = presc_cnt_q[0];
            PRESC_4: presc_level = presc_cnt_q[1];
            PRESC_8: presc_level = presc_cnt_q[2];
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            presc_prev_q <= 1'b0;
        else
            presc_prev_q <= presc_level;
    end

    // edges of the clock after the prescaler drive both catch and count
    assign tick_rise = presc_level && !presc_prev_q;
    assign tick_fall = !presc_level && presc_prev_q;

    // ------------------------------------------------------------
    // comparator catch and bypass
    // ------------------------------------------------------------
    cmp_catch_latch u_catch
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .capture (tick_fall),
        .d       (comparator_in),
        .q       (latched_result)
    );

    // bypass is purely combinational: fast, but can glitch the gate
    assign comparator_result = comparator_sync_enable ? latched_result : comparator_in;

    // ------------------------------------------------------------
    // gate source mux and timer
    // ------------------------------------------------------------
    // the gate pin is active low
    assign timer_gate_active = timer_gate_source_select ? !timer_gate_pin_n : comparator_result;
    assign count_en          = timer_on && (!timer_gate_enable || timer_gate_active);

    // counting on the rising edge keeps it clear of the falling-edge catch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timer_q <= '0;
        else if (tick_rise && count_en)
            timer_q <= timer_q + TIMER_W'(1);
    end

    assign timer_count = timer_q;

    // ------------------------------------------------------------
    // reference ladder
    // ------------------------------------------------------------
    assign ladder_power_on        = reference_enable;
    assign reference_range_select = lad_q[`LAD_RANGE_BIT];
    assign reference_level        = lad_q[`LAD_LEVEL_MSB:`LAD_LEVEL_LSB];

    // ratio in units of 1/96 supply: low is 4*level, high is 24 + 3*level
    always_comb
    begin
        ratio = 7'h00;
        if (!reference_enable)
            ratio = 7'h00;
        else if (reference_range_select)
            ratio = 7'({3'h0, reference_level} * `REF_LOW_STEP);
        else
            ratio = 7'(`REF_HIGH_BASE + {3'h0, reference_level} * `REF_HIGH_STEP);
    end

    assign comparator_reference_output = ratio;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_async;
        @(posedge clk) disable iff (!arst_n)
        !comparator_sync_enable |-> comparator_result == comparator_in;
    endproperty
    a_async: assert property (p_async) else $error("bypass not transparent");

    property p_sync_fwd;
        @(posedge clk) disable iff (!arst_n)
        comparator_sync_enable && tick_fall ##1 comparator_sync_enable |-> comparator_result == $past(comparator_in);
    endproperty
    a_sync_fwd: assert property (p_sync_fwd) else $error("synced result not caught value");

    property p_presc_edges;
        @(posedge clk) disable iff (!arst_n)
        (presc_sel != PRESC_1 && tick_fall) |-> $past(src_rise);
    endproperty
    a_presc_edges: assert property (p_presc_edges) else $error("prescaled fall not from divider");

    property p_count_rise;
        @(posedge clk) disable iff (!arst_n)
        tick_rise && count_en |=> timer_q == $past(timer_q) + TIMER_W'(1);
    endproperty
    a_count_rise: assert property (p_count_rise) else $error("timer missed rising edge");

    property p_no_count_fall;
        @(posedge clk) disable iff (!arst_n)
        !tick_rise |=> $stable(timer_q);
    endproperty
    a_no_count_fall: assert property (p_no_count_fall) else $error("timer moved off rising edge");

    property p_gate_src;
        @(posedge clk) disable iff (!arst_n)
        timer_gate_source_select |-> timer_gate_active == !timer_gate_pin_n;
    endproperty
    a_gate_src: assert property (p_gate_src) else $error("gate pin not selected");

    property p_gate_off;
        @(posedge clk) disable iff (!arst_n)
        !timer_on |=> $stable(timer_q);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("timer counted while off");

    property p_cfg_zero;
        @(posedge clk) disable iff (!arst_n)
        rd_en && cfg_hit |=> rd_data[7:2] == 6'h00;
    endproperty
    a_cfg_zero: assert property (p_cfg_zero) else $error("config upper bits not zero");

    property p_lad_zero;
        @(posedge clk) disable iff (!arst_n)
        rd_en && lad_hit |=> rd_data[6] == 1'b0 && rd_data[4] == 1'b0;
    endproperty
    a_lad_zero: assert property (p_lad_zero) else $error("ladder reserved bits not zero");

    property p_ref_off;
        @(posedge clk) disable iff (!arst_n)
        !reference_enable |-> comparator_reference_output == 7'h00 && !ladder_power_on;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("reference not grounded");

    property p_ref_high;
        @(posedge clk) disable iff (!arst_n)
        reference_enable && !reference_range_select |-> comparator_reference_output >= `REF_HIGH_BASE;
    endproperty
    a_ref_high: assert property (p_ref_high) else $error("high range below quarter");

    property p_independent;
        @(posedge clk) disable iff (!arst_n)
        wr_en && cfg_hit |=> $stable(lad_q);
    endproperty
    a_independent: assert property (p_independent) else $error("config write moved ladder");

    property p_power_on;
        @(posedge clk) disable iff (!arst_n)
        wr_en && lad_hit && wr_data[`LAD_EN_BIT] |=> ladder_power_on;
    endproperty
    a_power_on: assert property (p_power_on) else $error("ladder not powered");

    property p_gate_cmp;
        @(posedge clk) disable iff (!arst_n)
        !timer_gate_source_select |-> timer_gate_active == comparator_result;
    endproperty
    a_gate_cmp: assert property (p_gate_cmp) else $error("comparator not selected as gate");

    // a closed gate must freeze the count even while the timer runs
    property p_gate_block;
        @(posedge clk) disable iff (!arst_n)
        timer_on && timer_gate_enable && !timer_gate_active |=> $stable(timer_q);
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("timer counted with gate closed");

    // low range as a shift, so a wrong step constant shows up here
    property p_ref_low;
        @(posedge clk) disable iff (!arst_n)
        reference_enable && reference_range_select
        |-> comparator_reference_output == {1'b0, reference_level, 2'b00};
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("low range step wrong");

    property p_lad_fields;
        @(posedge clk) disable iff (!arst_n)
        wr_en && lad_hit |=> reference_level == $past(wr_data[3:0]) && reference_range_select == $past(wr_data[5]);
    endproperty
    a_lad_fields: assert property (p_lad_fields) else $error("ladder fields not written");

endmodule // cmp_sync_ref_ctrl

// File: tmr_src_model.sv
`timescale 1ns/1ps

module tmr_src_model
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       start,
    input  wire logic [7:0] periods,
    input  wire logic [3:0] half,
    output logic            timer_clk_src,
    output logic            busy
);
    logic [8:0] edges_q;
    logic [3:0] cnt_q;

    // burst of whole source periods; the source stands low between bursts, so no stray edge reaches the timer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timer_clk_src <= 1'b0;
            edges_q       <= 9'h000;
            cnt_q         <= 4'h0;
        end
        else if (start && edges_q == 9'h000)
        begin
            edges_q <= {periods, 1'b0};
            cnt_q   <= half;
        end
        else if (edges_q != 9'h000)
        begin
            // each level lasts half clocks, at least one, since the timer samples the source on clk
            if (cnt_q <= 4'h1)
            begin
                timer_clk_src <= ~timer_clk_src;
                edges_q       <= edges_q - 9'h001;
                cnt_q         <= half;
            end
            else
                cnt_q <= cnt_q - 4'h1;
        end
    end

    assign busy = (edges_q != 9'h000);
endmodule // tmr_src_model

// File: comparator_sync_vref_ctrl_bench.sv
`timescale 1ns/1ps

`define CHK(got, exp) \
    begin check_count++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR %0t got %h expected %h", $time, got, exp); end end

module comparator_sync_vref_ctrl_bench;
    typedef struct { logic [2:0] sel; logic [15:0] val; } note_t;
    logic clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rd_d = 1'b0, probe = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wr_data = 8'h00, rd_data, periods = 8'h00;
    logic        comparator_in = 1'b0, timer_clk_src, timer_on = 1'b0, timer_gate_enable = 1'b0;
    logic        timer_gate_pin_n = 1'b1, start = 1'b0, busy, comparator_result, timer_gate_active;
    logic [1:0]  timer_prescale = 2'h0;
    logic [15:0] timer_count, exp_cnt = 16'h0000;
    logic        ladder_power_on, reference_range_select;
    logic [3:0]  reference_level;
    logic [6:0]  comparator_reference_output;
    logic [7:0]  d;
    int          err_count = 0, check_count = 0, seed = 85;
    note_t       notes[$];

    cmp_sync_ref_ctrl u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .comparator_in(comparator_in), .timer_clk_src(timer_clk_src),
        .timer_prescale(timer_prescale), .timer_on(timer_on), .timer_gate_enable(timer_gate_enable),
        .timer_gate_pin_n(timer_gate_pin_n), .comparator_result(comparator_result),
        .timer_gate_active(timer_gate_active), .timer_count(timer_count), .ladder_power_on(ladder_power_on),
        .reference_range_select(reference_range_select), .reference_level(reference_level),
        .comparator_reference_output(comparator_reference_output));

    tmr_src_model u_src (.clk(clk), .arst_n(arst_n), .start(start), .periods(periods), .half(4'h2),
        .timer_clk_src(timer_clk_src), .busy(busy));

    initial
    begin
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // result watcher: read data one cycle after the strobe, or a probed output
    // ------------------------------------------------------------
    function automatic logic [15:0] pick(input logic [2:0] s);
        case (s)
            3'h0: pick = {8'h00, rd_data};
            3'h1: pick = {3'h0, ladder_power_on, reference_range_select, reference_level,
                          comparator_reference_output};
            3'h2: pick = {15'h0000, comparator_result};
            3'h3: pick = {15'h0000, timer_gate_active};
            default: pick = timer_count;
        endcase
    endfunction

    always @(posedge clk) rd_d <= rd_en;

    always @(negedge clk)
    begin : watch
        note_t n;
        if (rd_d || probe)
        begin
            if (notes.size() == 0)
            begin
                err_count++;
                $display("ERROR %0t result without a note", $time);
            end
            else
            begin
                n = notes.pop_front();
                `CHK(pick(n.sel), n.val)
            end
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] v);
        notes.push_back('{3'h0, {8'h00, v}});
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    task automatic probe_out(input logic [2:0] s, input logic [15:0] v);
        notes.push_back('{s, v});
        @(posedge clk);
        probe <= 1'b1;
        @(posedge clk);
        probe <= 1'b0;
    endtask

    // expected ladder outputs, reference counted in 1/96 of supply
    task automatic lad(input logic [7:0] v);
        logic [6:0] rf;
        rf = !v[7] ? 7'h00 : v[5] ? {1'b0, v[3:0], 2'b00} : 7'h18 + 7'(v[3:0]) * 7'h03;
        probe_out(3'h1, {3'h0, v[7], v[5], v[3:0], rf});
    endtask

    task automatic conclude();
        // a note that never met its result is a missed check
        if (notes.size() != 0)
        begin
            err_count++;
            $display("ERROR %0t results never seen", $time);
        end
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // runs n whole source periods, then lets the edge detection settle
    task automatic run_src(input logic [7:0] n);
        int i;
        @(posedge clk);
        periods <= n;
        start   <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 4000 && busy; i++)
            @(posedge clk);
        if (busy)
        begin
            err_count++;
            $display("ERROR %0t source burst hung", $time);
            conclude();
        end
        else
            repeat (3) @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(4'h0, 8'h02);
        rd(4'h1, 8'h00);
        rd(4'h5, 8'h00);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h03);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        for (int r = 0; r < 2; r++)
            for (int l = 0; l < 16; l++)
            begin
                d = {2'b10, r[0], 1'b0, l[3:0]};
                wr(4'h1, d);
                lad(d);
            end
        repeat (12)
        begin
            d = 8'($random(seed));
            wr(4'h1, d);
            rd(4'h1, d & 8'haf);
            lad(d);
        end
        // configuration writes leave the ladder alone
        wr(4'h1, 8'ha5);
        wr(4'h0, 8'h01);
        wr(4'h0, 8'h02);
        rd(4'h1, 8'ha5);
        lad(8'ha5);
        wr(4'h1, 8'h20);
        lad(8'h20);
        // gate source mux, async path
        for (int v = 0; v < 8; v++)
        begin
            wr(4'h0, {6'h00, v[2], 1'b0});
            comparator_in    <= v[0];
            timer_gate_pin_n <= v[1];
            probe_out(3'h2, {15'h0000, v[0]});
            probe_out(3'h3, {15'h0000, v[2] ? !v[1] : v[0]});
        end
        // sync latch, source stopped then running
        wr(4'h0, 8'h01);
        comparator_in <= 1'b1;
        probe_out(3'h2, 16'h0000);
        run_src(8'h02);
        probe_out(3'h2, 16'h0001);
        comparator_in <= 1'b0;
        probe_out(3'h2, 16'h0001);
        run_src(8'h06);
        probe_out(3'h2, 16'h0000);
        // timer counts once per prescaled rising edge
        wr(4'h0, 8'h00);
        timer_on <= 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            timer_prescale <= p[1:0];
            run_src(8'h10);
            exp_cnt = exp_cnt + (16'h0010 >> p);
            probe_out(3'h4, exp_cnt);
        end
        timer_prescale <= 2'h0;
        timer_on       <= 1'b0;
        run_src(8'h10);
        probe_out(3'h4, exp_cnt);
        timer_on          <= 1'b1;
        timer_gate_enable <= 1'b1;
        for (int v = 0; v < 4; v++)
        begin
            wr(4'h0, {6'h00, v[1], 1'b0});
            comparator_in    <= v[0];
            timer_gate_pin_n <= v[0];
            run_src(8'h10);
            if (v[1] ? !v[0] : v[0])
                exp_cnt = exp_cnt + 16'h0010;
            probe_out(3'h4, exp_cnt);
        end
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule // comparator_sync_vref_ctrl_bench
